// ---- common/stereo_link_consts.vh ----
// Purpose: Constants for the stereo converter serial link.
// Assumes: ref_clk at 125 MHz.
// Notes: Cycle counts are worked out for ref_clk and sized for their counters.
`ifndef STEREO_LINK_CONSTS_VH
`define STEREO_LINK_CONSTS_VH

// Clock rate in MHz and Hz
`define CLK_MHZ 125
`define CLK_HZ 125000000

// Bit clock half period, ns (80 ns bit period)
`define BIT_HALF_NS 40
// Stereo sample rate, Hz
`define SAMPLE_HZ 44100
// Convert command high time, ns
`define CMD_HIGH_NS 80
// Converter reset hold time, ns
`define RST_HOLD_NS 2000

// Word layout
`define WORD_BITS 32
`define CH0_LSB 0
`define CH1_LSB 16
`define CH_BITS 16

// Counter widths
`define BIT_CNT_W 3
`define TIMER_W 12
`define RST_CNT_W 8
`define SHIFT_CNT_W 6

// Cycle counts at 125 MHz, sized for their counters
`define BIT_HALF_CYCLES 3'h5
`define CMD_PERIOD_CYCLES 12'hB12
`define CMD_HIGH_CYCLES 12'h00A
`define RST_HOLD_CYCLES 8'hFA
`define WORD_LEN_BITS 6'h20

`endif

// ---- src/stereo_link.v ----
// Purpose: Serial link from a processor port to a stereo ADC and DAC pair in cascade mode.
// Assumes: Converters sample on the falling bit clock edge and shift on the rising edge.
// Notes: The bit clock is looped back externally and used as the receive clock.
// Summary of operation
// - A convert command pulse goes out on the timer output pin once per stereo sample period.
// - The 32-bit ADC word arrives most significant bit first on the receive data pin.
// - The block makes the bit clock on the transmit clock pin, shared by the ADC and the DAC.
// - The receiver is clocked from the transmit bit clock, fed back as the receive clock.
// - The receive clock is sampled by ref_clk, so bits are taken at the full bit rate.
// - The DAC sync strobe requests the next 32-bit stereo word, which the block then shifts out.
// - One transmit data pin feeds both DAC serial inputs with the same stream.
// - The bit clock runs at full rate and the convert timer gives about 44.1 kHz stereo samples.
// - Each completed incoming word raises a one-cycle receive event.
// - Channel zero sits in the low 16 bits and channel one in the high 16 bits, signed.
`include "stereo_link_consts.vh"
`default_nettype none

module stereo_link (
    input wire ref_clk,
    input wire reset_n,
    input wire link_enable,
    input wire tx_valid,
    input wire [`WORD_BITS-1:0] tx_data,
    output reg tx_ready,
    output reg [`WORD_BITS-1:0] rx_data,
    output reg rx_event,
    output reg tx_underrun,
    input wire receive_clock_pin,
    input wire receive_data_pin,
    input wire adc_sync_pin,
    input wire dac_sync_pin,
    output reg transmit_clock_pin,
    output reg transmit_data_pin,
    output reg timer_output_pin,
    output reg converter_reset_n
);

    // Counts come from the header already sized, so nothing is cut here
    localparam [`BIT_CNT_W-1:0] BIT_HALF_CYC = `BIT_HALF_CYCLES;
    // A period of whole cycles runs a little fast of 44.1 kHz
    localparam [`TIMER_W-1:0] CMD_PERIOD_CYC = `CMD_PERIOD_CYCLES;
    localparam [`TIMER_W-1:0] CMD_HIGH_CYC = `CMD_HIGH_CYCLES;
    localparam [`RST_CNT_W-1:0] RST_HOLD_CYC = `RST_HOLD_CYCLES;
    localparam [`SHIFT_CNT_W-1:0] WORD_LEN = `WORD_LEN_BITS;

    // Link state, one-hot
    localparam [2:0] ST_RESET = 3'h1;
    localparam [2:0] ST_IDLE = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;

    reg [2:0] state_q;
    reg [`RST_CNT_W-1:0] rst_cnt_q;
    reg [`BIT_CNT_W-1:0] bit_cnt_q;
    reg [`TIMER_W-1:0] timer_q;
    wire running;
    wire bclk_rise;
    wire bclk_fall;

    // Pin synchronisers
    reg rclk_s1, rclk_s2, rclk_s3;
    reg rxd_s1, rxd_s2;
    reg adc_s1, adc_s2;
    reg dac_s1, dac_s2;
    wire rclk_fall;

    // Receive shifter
    reg [`WORD_BITS-1:0] rx_sh_q;
    reg [`SHIFT_CNT_W-1:0] rx_cnt_q;
    reg rx_busy_q;

    // Transmit shifter
    reg [`WORD_BITS-1:0] tx_sh_q;
    reg [`SHIFT_CNT_W-1:0] tx_cnt_q;
    reg tx_load_q;

    // Two-entry transmit buffer
    reg [`WORD_BITS-1:0] buf_mem [0:1];
    reg buf_wr_q, buf_rd_q;
    reg [1:0] buf_cnt_q;
    reg [1:0] buf_cnt_d;
    wire buf_push;
    wire buf_pop;
    wire buf_empty;

    assign running = (state_q == ST_RUN);
    assign bclk_rise = running && !transmit_clock_pin && (bit_cnt_q == BIT_HALF_CYC - 3'h1);
    assign bclk_fall = running && transmit_clock_pin && (bit_cnt_q == BIT_HALF_CYC - 3'h1);

    // Converter reset sequence, then wait for enable
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_RESET;
            rst_cnt_q <= 8'h00;
            converter_reset_n <= 1'b0;
        end else begin
            case (state_q)
                ST_RESET: begin
                    if (rst_cnt_q == RST_HOLD_CYC - 8'h01) begin
                        converter_reset_n <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        rst_cnt_q <= rst_cnt_q + 8'h01;
                    end
                end
                ST_IDLE: begin
                    if (link_enable) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Stop only while the bit clock is low; a stop on the rising count still lets a one-cycle runt pulse out
                    if (!link_enable && !transmit_clock_pin) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_RESET;
                end
            endcase
        end
    end

    // Bit clock divider, full rate for a 80 ns bit period
    // The divider restarts on each run, so the first half period is full length
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_q <= 3'h0;
            transmit_clock_pin <= 1'b0;
        end else if (!running) begin
            bit_cnt_q <= 3'h0;
            transmit_clock_pin <= 1'b0;
        end else if (bit_cnt_q == BIT_HALF_CYC - 3'h1) begin
            bit_cnt_q <= 3'h0;
            transmit_clock_pin <= ~transmit_clock_pin;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // Convert timer: one high pulse per stereo sample period
    // The first command leaves on the first running edge
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_q <= 12'h000;
            timer_output_pin <= 1'b0;
        end else if (!running) begin
            timer_q <= 12'h000;
            timer_output_pin <= 1'b0;
        end else begin
            if (timer_q == CMD_PERIOD_CYC - 12'h001) begin
                timer_q <= 12'h000;
            end else begin
                timer_q <= timer_q + 12'h001;
            end
            timer_output_pin <= (timer_q < CMD_HIGH_CYC);
        end
    end

    // Two flip-flops on every pin before any logic looks at it
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rclk_s1 <= 1'b0;
            rclk_s2 <= 1'b0;
            rclk_s3 <= 1'b0;
            rxd_s1 <= 1'b0;
            rxd_s2 <= 1'b0;
            adc_s1 <= 1'b0;
            adc_s2 <= 1'b0;
            dac_s1 <= 1'b0;
            dac_s2 <= 1'b0;
        end else begin
            rclk_s1 <= receive_clock_pin;
            rclk_s2 <= rclk_s1;
            rclk_s3 <= rclk_s2;
            rxd_s1 <= receive_data_pin;
            rxd_s2 <= rxd_s1;
            adc_s1 <= adc_sync_pin;
            adc_s2 <= adc_s1;
            dac_s1 <= dac_sync_pin;
            dac_s2 <= dac_s1;
        end
    end

    // Data and strobe share the clock's sync delay, so the sample stays aligned
    assign rclk_fall = rclk_s3 && !rclk_s2;

    // Receiver: framed by the ADC strobe, MSB first
    // No back-pressure: a word not taken before the next event is lost
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sh_q <= 32'h00000000;
            rx_cnt_q <= 6'h00;
            rx_busy_q <= 1'b0;
            rx_data <= 32'h00000000;
            rx_event <= 1'b0;
        end else begin
            rx_event <= 1'b0;
            if (rclk_fall && running) begin
                if (adc_s2) begin
                    // A strobe restarts framing even mid-word
                    rx_sh_q <= {31'h0, rxd_s2};
                    rx_cnt_q <= 6'h01;
                    rx_busy_q <= 1'b1;
                end else if (rx_busy_q) begin
                    rx_sh_q <= {rx_sh_q[`WORD_BITS-2:0], rxd_s2};
                    rx_cnt_q <= rx_cnt_q + 6'h01;
                end
                if (rx_busy_q && !adc_s2 && rx_cnt_q == WORD_LEN - 6'h01) begin
                    // Channel 1 in the high half, channel 0 in the low half
                    rx_data <= {rx_sh_q[`WORD_BITS-2:0], rxd_s2};
                    rx_event <= 1'b1;
                    rx_busy_q <= 1'b0;
                end
            end
        end
    end

    // Transmit buffer; a stalled shifter leaves it full and drops tx_ready
    assign buf_empty = (buf_cnt_q == 2'h0);
    assign buf_push = tx_valid && tx_ready;
    assign buf_pop = bclk_rise && tx_load_q && !buf_empty;

    always @* begin
        buf_cnt_d = buf_cnt_q;
        if (buf_push && !buf_pop) begin
            buf_cnt_d = buf_cnt_q + 2'h1;
        end else if (buf_pop && !buf_push) begin
            buf_cnt_d = buf_cnt_q - 2'h1;
        end
    end

    always @(posedge ref_clk) begin
        if (buf_push) begin
            buf_mem[buf_wr_q] <= tx_data;
        end
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            buf_cnt_q <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            if (buf_push) begin
                buf_wr_q <= ~buf_wr_q;
            end
            if (buf_pop) begin
                buf_rd_q <= ~buf_rd_q;
            end
            buf_cnt_q <= buf_cnt_d;
            tx_ready <= (buf_cnt_d != 2'h2);
        end
    end

    // Transmitter: DAC strobe seen at a falling edge loads on the next rising edge
    // The pop and the first bit share one edge, so tx_ready rises as the MSB leaves
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_load_q <= 1'b0;
            tx_sh_q <= 32'h00000000;
            tx_cnt_q <= 6'h00;
            transmit_data_pin <= 1'b0;
            tx_underrun <= 1'b0;
        end else begin
            tx_underrun <= 1'b0;
            if (!running) begin
                tx_load_q <= 1'b0;
                tx_cnt_q <= 6'h00;
            end else if (bclk_fall && dac_s2) begin
                tx_load_q <= 1'b1;
            end else if (bclk_rise) begin
                if (tx_load_q) begin
                    tx_load_q <= 1'b0;
                    tx_cnt_q <= WORD_LEN - 6'h01;
                    if (buf_empty) begin
                        // Silence rather than a stale word when software falls behind
                        tx_sh_q <= 32'h00000000;
                        transmit_data_pin <= 1'b0;
                        tx_underrun <= 1'b1;
                    end else begin
                        tx_sh_q <= {buf_mem[buf_rd_q][`WORD_BITS-2:0], 1'b0};
                        transmit_data_pin <= buf_mem[buf_rd_q][`WORD_BITS-1];
                    end
                end else if (tx_cnt_q != 6'h00) begin
                    transmit_data_pin <= tx_sh_q[`WORD_BITS-1];
                    tx_sh_q <= {tx_sh_q[`WORD_BITS-2:0], 1'b0};
                    tx_cnt_q <= tx_cnt_q - 6'h01;
                end else begin
                    transmit_data_pin <= 1'b0;
                end
            end
        end
    end

endmodule // stereo_link

`default_nettype wire

// ---- verif/stereo_link_asserts.sv ----
// Purpose: Pin timing checks for the stereo link.
// Assumes: Single ref_clk domain, async active-low reset.
// Notes: Reset hold allows one cycle either way of the nominal count.
`include "stereo_link_consts.vh"
`default_nettype none
module stereo_link_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic link_enable,
    input wire logic [`WORD_BITS-1:0] rx_data,
    input wire logic rx_event,
    input wire logic transmit_clock_pin,
    input wire logic transmit_data_pin,
    input wire logic timer_output_pin,
    input wire logic converter_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [11:0] per_q;
    reg seen_q;
    reg [8:0] hold_q;
    // Period is only judged between two pulses of one enabled run
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            per_q <= 12'h000;
            seen_q <= 1'b0;
            hold_q <= 9'h000;
        end else begin
            per_q <= $rose(timer_output_pin) ? 12'h000 : per_q + 12'h001;
            seen_q <= link_enable && (seen_q || $rose(timer_output_pin));
            if (!converter_reset_n)
                hold_q <= hold_q + 9'h001;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_cmd_width: assert property ($rose(timer_output_pin) |=> timer_output_pin [*8] ##1 timer_output_pin
        ##1 !timer_output_pin) else $error("convert width wrong");
    a_cmd_period: assert property ($rose(timer_output_pin) && seen_q |-> per_q == 12'hB11)
        else $error("convert period wrong");
    a_bit_high: assert property ($rose(transmit_clock_pin) |=> transmit_clock_pin [*4]
        ##1 !transmit_clock_pin) else $error("bit clock high time wrong");
    a_reset_hold: assert property ($rose(converter_reset_n) |-> hold_q >= 9'h0F9 && hold_q <= 9'h0FB)
        else $error("converter reset hold wrong");
    a_idle_in_reset: assert property (!converter_reset_n |-> !transmit_clock_pin && !timer_output_pin)
        else $error("link active in converter reset");
    a_rx_pulse: assert property (rx_event |=> !rx_event)
        else $error("receive event too long");
    a_rx_hold: assert property ($changed(rx_data) |-> rx_event)
        else $error("receive word changed without event");
    a_tx_on_rise: assert property ($changed(transmit_data_pin) && $past(link_enable) |->
        $rose(transmit_clock_pin)) else $error("transmit bit off the rising edge");
    c_rx: cover property (rx_event);
    c_cmd: cover property ($rose(timer_output_pin) && seen_q);
    c_rst: cover property ($rose(converter_reset_n));
endmodule // stereo_link_asserts
bind stereo_link stereo_link_asserts checker_i (.ref_clk, .reset_n, .link_enable, .rx_data, .rx_event,
    .transmit_clock_pin, .transmit_data_pin, .timer_output_pin, .converter_reset_n);
`default_nettype wire

// ---- verif/converter_pair_model.sv ----
// Purpose: Behavioural stereo ADC and DAC pair in cascade mode.
// Assumes: Shifts on the rising and samples on the falling bit clock.
// Notes: Idle ADC data toggles so stale bits never look valid.
`default_nettype none
module converter_pair_model (
    input wire logic bit_clk,
    input wire logic convert,
    input wire logic rst_n,
    input wire logic sin,
    input wire logic [31:0] adc_word,
    output logic adc_sync,
    output logic sout,
    output logic dac_sync,
    output logic [31:0] dac_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] nxt, sh, ds, rx;
    logic go;
    int an, dn;
    initial begin
        {adc_sync, sout, dac_sync, go, nxt, sh, ds, rx, dac_word} = '0;
        an = 0;
        dn = 0;
    end
    always @(posedge convert) if (rst_n) begin
        sh = nxt;
        nxt = adc_word;
        dac_word = rx;
        go = 1;
    end
    always @(posedge bit_clk) begin
        #1;
        adc_sync = go;
        dac_sync = go;
        if (go)
            an = 32;
        go = 0;
        sout = (an > 0) ? sh[an-1] : ~sout;
        if (an > 0)
            an--;
    end
    always @(negedge bit_clk) begin
        if (dac_sync)
            dn = 32;
        else if (dn > 0) begin
            ds = {ds[30:0], sin};
            dn--;
            if (dn == 0)
                rx = ds;
        end
    end
endmodule // converter_pair_model
`default_nettype wire

// ---- verif/stereo_link_tb.sv ----
// Purpose: Self-checking bench for the stereo link.
// Assumes: Bit clock looped back to the receive clock pin.
// Notes: The DAC word shows only at the next convert, so it is checked one frame late.
`default_nettype none
module stereo_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, reset_n = 0, link_enable = 1, tx_valid = 0, und_seen = 0;
    logic [31:0] tx_data = 0, adc_word = 0, prev_adc = 0, last_tx = 0;
    logic [31:0] rows [4][2] = '{'{32'h7FFF_8000, 32'h1234_ABCD}, '{32'h0001_FFFF, 32'hFFFF_0000},
        '{32'hA5A5_5A5A, 32'h0000_FFFF}, '{32'h8000_7FFF, 32'h8001_7FFE}};
    wire [31:0] rx_data, dac_word;
    wire tx_ready, rx_event, tx_underrun, adc_sync, dac_sync, sout, tclk, tdat, cmd, crst_n;
    int num_errors = 0, comparisons = 0, cycles = 0;
    stereo_link DUT (.ref_clk, .reset_n, .link_enable, .tx_valid, .tx_data, .tx_ready, .rx_data, .rx_event,
        .tx_underrun, .receive_clock_pin(tclk), .receive_data_pin(sout), .adc_sync_pin(adc_sync),
        .dac_sync_pin(dac_sync), .transmit_clock_pin(tclk), .transmit_data_pin(tdat),
        .timer_output_pin(cmd), .converter_reset_n(crst_n));
    converter_pair_model peer (.bit_clk(tclk), .convert(cmd), .rst_n(crst_n), .sin(tdat), .adc_word,
        .adc_sync, .sout, .dac_sync, .dac_word);
    always #4 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        cycles++;
        if (tx_underrun === 1'b1)
            und_seen = 1;
        if (cycles == 40000) begin
            num_errors++;
            final_report;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic push(input logic [31:0] w);
        @(negedge ref_clk);
        tx_valid = 1;
        tx_data = w;
        while (tx_ready !== 1'b1) @(negedge ref_clk);
        @(negedge ref_clk);
        tx_valid = 0;
    endtask
    task automatic frame(input logic [31:0] w);
        logic [31:0] exp;
        while (cmd !== 1'b1) @(negedge ref_clk);
        exp = prev_adc;
        prev_adc = adc_word;
        repeat (3) @(negedge ref_clk);
        check("dac word", dac_word, last_tx);
        last_tx = w;
        while (rx_event !== 1'b1) @(negedge ref_clk);
        check("rx word", rx_data, exp);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge ref_clk);
        reset_n = 1;
        for (int i = 0; i < 4; i++) begin
            adc_word = rows[i][1];
            push(rows[i][0]);
            frame(rows[i][0]);
            $display("row %0d done", i);
        end
        push(32'h1111_2222);
        push(32'h3333_4444);
        check("ready when full", tx_ready, 0);
        fork
            push(32'h5555_6666);
            frame(32'h1111_2222);
        join
        frame(32'h3333_4444);
        frame(32'h5555_6666);
        $display("full buffer done");
        und_seen = 0;
        frame(32'h0);
        check("underrun", und_seen, 1);
        frame(32'h0);
        $display("underrun done");
        link_enable = 0;
        repeat (20) @(negedge ref_clk);
        check("pins when disabled", {cmd, tclk}, 0);
        link_enable = 1;
        frame(32'h0);
        $display("disable done");
        @(negedge ref_clk);
        reset_n = 0;
        #1;
        check("ready in reset", tx_ready, 0);
        check("pins in reset", {crst_n, cmd, tclk}, 0);
        @(negedge ref_clk);
        reset_n = 1;
        @(negedge ref_clk);
        check("ready after reset", tx_ready, 1);
        repeat (240) @(negedge ref_clk);
        check("converter reset held", crst_n, 0);
        repeat (20) @(negedge ref_clk);
        check("converter reset freed", crst_n, 1);
        $display("reset done");
        final_report;
    end
endmodule // stereo_link_tb
`default_nettype wire
